// ---- logic/tpg_packet_gen.sv ----
// Module: test packet generator with Avalon-MM registers and byte stream
// Summary of operation
// RULE_01: Frames are produced only while enable and run are both set; the code finishes a frame already begun after either bit clears.
// RULE_02: Continuous mode never halts; frames counted in ten-thousand blocks.
// RULE_03: Burst mode sends thirty million frames, then halts by itself.
// RULE_04: Leaving continuous mode stops at the next ten-thousand boundary.
// RULE_05: Length field picks 125, 64, 1518 or 10000 byte frames.
// RULE_06: Gap bit spaces frames by 96 ns or 8192 ns; the code rounds these up to 10 or 820 cycles of 10 ns (100 ns or 8200 ns).
// RULE_07: Destination address is all ones with a programmable low nibble.
// RULE_08: Source address is all ones with a programmable low nibble.
// RULE_09: Payload-type one fills payload from a pseudo random sequence.
// RULE_10: Payload-type zero repeats the 16-bit pattern word over the payload.
// RULE_11: Bad-FCS bit corrupts the appended FCS, otherwise FCS is correct.
// RULE_12: Control changes during a run apply only after run restart.
// RULE_13: Pattern changes during a run apply only after run restart.
// RULE_14: Software keeps the generator off a live network.
//
// Local design decision: the Avalon-MM interface to the registers.
`default_nettype none
module tpg_packet_gen #(
  parameter int unsigned BLOCK_PKTS = 10000,
  parameter int unsigned BURST_PKTS = 30000000
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Transmit byte stream
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  output logic tx_last_o,
  input wire logic tx_ready_i
);
  // ==========================================================
  // Functions
  // ==========================================================
  function automatic logic [13:0] frame_len(input logic [1:0] sel);
    case (sel)
      tpg_pkg::LEN_SEL_64: frame_len = tpg_pkg::LEN_64;
      tpg_pkg::LEN_SEL_1518: frame_len = tpg_pkg::LEN_1518;
      tpg_pkg::LEN_SEL_JUMBO: frame_len = tpg_pkg::LEN_JUMBO;
      default: frame_len = tpg_pkg::LEN_125;
    endcase
  endfunction

  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ tpg_pkg::CRC_POLY) : (r >> 1);
    end
    crc_byte = r;
  endfunction

  function automatic logic [15:0] wr_merge(input logic [15:0] old,
                                           input logic [31:0] w,
                                           input logic [3:0] be);
    wr_merge = {be[1] ? w[15:8] : old[15:8], be[0] ? w[7:0] : old[7:0]};
  endfunction

  // ==========================================================
  // State
  // ==========================================================
  localparam tpg_pkg::tpg_regs_type REGS_RST = '{
    st: tpg_pkg::ST_IDLE, idx: '0, gap: '0, crc: tpg_pkg::CRC_INIT,
    lfsr: tpg_pkg::LFSR_SEED, cfg: '0, pat: '0, blk: '0, tot: '0,
    done: 1'b0, armed: 1'b0, ctrl: tpg_pkg::CTRL_RST,
    patreg: tpg_pkg::PAT_RST, wait_req: 1'b1, rdata: '0,
    out_v: 1'b0, out_d: '0, out_l: 1'b0,
    sk_v: 1'b0, sk_d: '0, sk_l: 1'b0};

  tpg_pkg::tpg_regs_type q;
  tpg_pkg::tpg_regs_type d;
  logic go;
  logic start;
  logic fire;
  logic pay;
  logic fcs_first;
  logic glast;
  logic stop;
  logic [13:0] flen;
  logic [13:0] fcs_pos;
  logic [7:0] gbyte;
  logic [13:0] blk_n;
  logic [24:0] tot_n;

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    d = q;
    go = q.ctrl[tpg_pkg::EN_BIT] & q.ctrl[tpg_pkg::RUN_BIT]; // RULE_01
    start = (q.st == tpg_pkg::ST_IDLE) && go && q.armed;
    flen = frame_len(q.cfg[tpg_pkg::LEN_HI:tpg_pkg::LEN_LO]); // RULE_05
    fcs_pos = q.idx - (flen - tpg_pkg::FCS_LEN);
    pay = (q.idx >= tpg_pkg::HDR_LEN) && (q.idx < flen - tpg_pkg::FCS_LEN);
    fcs_first = (q.idx == flen - tpg_pkg::FCS_LEN);
    glast = (q.idx == flen - 14'h0001);
    fire = (q.st == tpg_pkg::ST_FRAME) && !q.sk_v;
    blk_n = (q.blk == 14'(BLOCK_PKTS - 1)) ? '0 : q.blk + 14'h0001;
    tot_n = q.tot + 25'h0000001;
    if (q.cfg[tpg_pkg::CONT_BIT]) begin
      stop = !q.ctrl[tpg_pkg::CONT_BIT] && (blk_n == '0); // RULE_02 RULE_04
    end else begin
      stop = (tot_n == 25'(BURST_PKTS)); // RULE_03
    end
    // Frame byte at the current index
    if (q.idx <= tpg_pkg::DA_LAST) begin
      gbyte = (q.idx == tpg_pkg::DA_LAST) ? // RULE_07
        {tpg_pkg::ADDR_FILL[7:4], q.cfg[tpg_pkg::DA_HI:tpg_pkg::DA_LO]} :
        tpg_pkg::ADDR_FILL;
    end else if (q.idx <= tpg_pkg::SA_LAST) begin
      gbyte = (q.idx == tpg_pkg::SA_LAST) ? // RULE_08
        {tpg_pkg::ADDR_FILL[7:4], q.cfg[tpg_pkg::SA_HI:tpg_pkg::SA_LO]} :
        tpg_pkg::ADDR_FILL;
    end else if (q.idx < tpg_pkg::HDR_LEN) begin
      gbyte = (q.idx == tpg_pkg::TYPE_HI) ? tpg_pkg::ETHERTYPE[15:8] :
        tpg_pkg::ETHERTYPE[7:0];
    end else if (pay) begin
      if (q.cfg[tpg_pkg::RAND_BIT]) begin
        gbyte = q.lfsr[7:0]; // RULE_09
      end else begin
        gbyte = q.idx[0] ? q.pat[7:0] : q.pat[15:8]; // RULE_10
      end
    end else begin
      gbyte = ~q.crc[{fcs_pos[1:0], 3'b000} +: 8] ^
        ((fcs_first && q.cfg[tpg_pkg::BADFCS_BIT]) ?
         tpg_pkg::FCS_CORRUPT : 8'h00); // RULE_11
    end

    // Generator
    if (!go) begin
      d.armed = 1'b1;
    end
    case (q.st)
      tpg_pkg::ST_IDLE: begin
        if (start) begin
          d.st = tpg_pkg::ST_FRAME;
          d.armed = 1'b0;
          d.idx = '0;
          d.crc = tpg_pkg::CRC_INIT;
          d.lfsr = tpg_pkg::LFSR_SEED;
          d.cfg = q.ctrl[tpg_pkg::CFG_W-1:0]; // RULE_12
          d.pat = q.patreg; // RULE_13
          d.blk = '0;
          d.tot = '0;
          d.done = 1'b0;
        end
      end
      tpg_pkg::ST_FRAME: begin
        if (fire) begin
          d.idx = q.idx + 14'h0001;
          if (q.idx < flen - tpg_pkg::FCS_LEN) begin
            d.crc = crc_byte(q.crc, gbyte); // RULE_11
          end
          if (pay) begin
            d.lfsr = {1'b0, q.lfsr[15:1]} ^
              (q.lfsr[0] ? tpg_pkg::LFSR_TAPS : 16'h0000); // RULE_09
          end
          if (glast) begin
            d.idx = '0;
            d.crc = tpg_pkg::CRC_INIT;
            d.blk = blk_n;
            d.tot = tot_n;
            if (stop) begin
              d.st = tpg_pkg::ST_IDLE;
              d.done = 1'b1;
            end else if (!go || q.armed) begin
              d.st = tpg_pkg::ST_IDLE; // RULE_01 RULE_12
            end else begin
              d.st = tpg_pkg::ST_GAP;
              d.gap = (q.cfg[tpg_pkg::GAP_BIT] ? tpg_pkg::IPG_LONG_CYC :
                       tpg_pkg::IPG_SHORT_CYC) - 10'h001; // RULE_06
            end
          end
        end
      end
      tpg_pkg::ST_GAP: begin
        if (!go || q.armed) begin
          d.st = tpg_pkg::ST_IDLE;
        end else if (q.gap == '0) begin
          d.st = tpg_pkg::ST_FRAME;
        end else begin
          d.gap = q.gap - 10'h001; // RULE_06
        end
      end
      default: d.st = tpg_pkg::ST_IDLE;
    endcase

    // Two-entry output buffer
    if (!q.out_v || tx_ready_i) begin
      if (q.sk_v) begin
        d.out_v = 1'b1;
        d.out_d = q.sk_d;
        d.out_l = q.sk_l;
        d.sk_v = 1'b0;
      end else begin
        d.out_v = fire;
        d.out_d = gbyte;
        d.out_l = glast;
      end
    end else if (fire) begin
      d.sk_v = 1'b1;
      d.sk_d = gbyte;
      d.sk_l = glast;
    end

    // Register bus
    d.wait_req = 1'b1;
    if ((avs_read_i || avs_write_i) && q.wait_req) begin
      d.wait_req = 1'b0;
      case (avs_address_i)
        tpg_pkg::CTRL_ADDR: d.rdata = 32'(q.ctrl);
        tpg_pkg::PAT_ADDR: d.rdata = 32'(q.patreg);
        tpg_pkg::STAT_ADDR: begin
          d.rdata = '0;
          d.rdata[tpg_pkg::STAT_BUSY_BIT] = (q.st != tpg_pkg::ST_IDLE);
          d.rdata[tpg_pkg::STAT_DONE_BIT] = q.done;
        end
        default: d.rdata = '0;
      endcase
    end
    if (avs_write_i && !q.wait_req) begin
      case (avs_address_i)
        tpg_pkg::CTRL_ADDR:
          d.ctrl = wr_merge(q.ctrl, avs_writedata_i, avs_byteenable_i);
        tpg_pkg::PAT_ADDR:
          d.patreg = wr_merge(q.patreg, avs_writedata_i, avs_byteenable_i);
        default: d.rdata = q.rdata;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= REGS_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign avs_readdata_o = q.rdata;
  assign avs_waitrequest_o = q.wait_req;
  assign tx_data_o = q.out_d;
  assign tx_valid_o = q.out_v;
  assign tx_last_o = q.out_l;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  idle_hold_a: assert property ( // RULE_01
    q.st == tpg_pkg::ST_IDLE && !go |=> q.st == tpg_pkg::ST_IDLE)
    else $error("Generator left idle without enable and run");
  cont_endless_a: assert property ( // RULE_02
    q.cfg[tpg_pkg::CONT_BIT] && q.ctrl[tpg_pkg::CONT_BIT] && !q.done
    |=> !q.done)
    else $error("Continuous mode halted by itself");
  burst_stop_a: assert property ( // RULE_03
    $rose(q.done) && !q.cfg[tpg_pkg::CONT_BIT]
    |-> q.tot == 25'(BURST_PKTS) && q.st == tpg_pkg::ST_IDLE)
    else $error("Burst halted at wrong count");
  block_stop_a: assert property ( // RULE_04
    $rose(q.done) && q.cfg[tpg_pkg::CONT_BIT]
    |-> q.blk == '0 && !$past(q.ctrl[tpg_pkg::CONT_BIT]))
    else $error("Continuous stop off a block boundary");
  frame_len_a: assert property ( // RULE_05
    fire && glast |-> q.idx + 14'h0001 ==
      frame_len(q.cfg[tpg_pkg::LEN_HI:tpg_pkg::LEN_LO]) ##1 q.idx == '0)
    else $error("Frame length does not match selection");
  gap_len_a: assert property ( // RULE_06
    $rose(q.st == tpg_pkg::ST_GAP) |-> q.gap + 10'h001 ==
      (q.cfg[tpg_pkg::GAP_BIT] ? tpg_pkg::IPG_LONG_CYC :
       tpg_pkg::IPG_SHORT_CYC))
    else $error("Interframe gap length wrong");
  dest_addr_a: assert property ( // RULE_07
    fire && q.idx == tpg_pkg::DA_LAST
    |=> q.out_d[3:0] == q.cfg[tpg_pkg::DA_HI:tpg_pkg::DA_LO] || q.sk_v)
    else $error("Destination nibble wrong");
  src_addr_a: assert property ( // RULE_08
    fire && q.idx == tpg_pkg::SA_LAST
    |-> gbyte[3:0] == q.cfg[tpg_pkg::SA_HI:tpg_pkg::SA_LO])
    else $error("Source nibble wrong");
  rand_step_a: assert property ( // RULE_09
    fire && pay && q.cfg[tpg_pkg::RAND_BIT] |=> q.lfsr != $past(q.lfsr))
    else $error("Random payload sequence stalled");
  fixed_pat_a: assert property ( // RULE_10
    fire && pay && !q.cfg[tpg_pkg::RAND_BIT]
    |-> gbyte == (q.idx[0] ? q.pat[7:0] : q.pat[15:8]))
    else $error("Payload byte differs from pattern");
  bad_fcs_a: assert property ( // RULE_11
    fire && fcs_first |-> gbyte == (~q.crc[7:0] ^
      (q.cfg[tpg_pkg::BADFCS_BIT] ? tpg_pkg::FCS_CORRUPT : 8'h00)))
    else $error("FCS byte wrong for bad-FCS setting");
  cfg_hold_a: assert property ( // RULE_12
    q.st != tpg_pkg::ST_IDLE |=> $stable(q.cfg))
    else $error("Configuration changed during a run");
  pat_hold_a: assert property ( // RULE_13
    q.st != tpg_pkg::ST_IDLE |=> $stable(q.pat))
    else $error("Pattern changed during a run");
  stall_hold_a: assert property (
    q.out_v && !tx_ready_i |=> q.out_v && $stable(q.out_d))
    else $error("Output word lost under stall");
endmodule
`default_nettype wire

// ---- logic/tpg_pkg.sv ----
// Package: constants and state types of the test packet generator
`default_nettype none
package tpg_pkg;
  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [5:0] CTRL_IDX = 6'h1D;
  localparam logic [5:0] PAT_IDX = 6'h1E;
  localparam logic [5:0] STAT_IDX = 6'h1F;
  localparam logic [7:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
  localparam logic [7:0] PAT_ADDR = {PAT_IDX, 2'b00};
  localparam logic [7:0] STAT_ADDR = {STAT_IDX, 2'b00};
  localparam logic [15:0] CTRL_RST = 16'h0040;
  localparam logic [15:0] PAT_RST = 16'h0000;
  // Control fields
  localparam int EN_BIT = 15;
  localparam int RUN_BIT = 14;
  localparam int CONT_BIT = 13;
  localparam int LEN_HI = 12;
  localparam int LEN_LO = 11;
  localparam int GAP_BIT = 10;
  localparam int DA_HI = 9;
  localparam int DA_LO = 6;
  localparam int SA_HI = 5;
  localparam int SA_LO = 2;
  localparam int RAND_BIT = 1;
  localparam int BADFCS_BIT = 0;
  localparam int CFG_W = 14;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  // ==========================================================
  // Frame layout
  // ==========================================================
  localparam logic [1:0] LEN_SEL_64 = 2'h1;
  localparam logic [1:0] LEN_SEL_1518 = 2'h2;
  localparam logic [1:0] LEN_SEL_JUMBO = 2'h3;
  localparam logic [13:0] LEN_125 = 14'h007D;
  localparam logic [13:0] LEN_64 = 14'h0040;
  localparam logic [13:0] LEN_1518 = 14'h05EE;
  localparam logic [13:0] LEN_JUMBO = 14'h2710;
  localparam logic [13:0] DA_LAST = 14'h0005;
  localparam logic [13:0] SA_LAST = 14'h000B;
  localparam logic [13:0] TYPE_HI = 14'h000C;
  localparam logic [13:0] HDR_LEN = 14'h000E;
  localparam logic [13:0] FCS_LEN = 14'h0004;
  localparam logic [15:0] ETHERTYPE = 16'h88B5;
  localparam logic [7:0] ADDR_FILL = 8'hFF;
  localparam logic [7:0] FCS_CORRUPT = 8'hFF;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;
  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_NS = 10;
  localparam int IPG_SHORT_NS = 96;
  localparam int IPG_LONG_NS = 8192;
  localparam logic [9:0] IPG_SHORT_CYC =
    10'((IPG_SHORT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0] IPG_LONG_CYC =
    10'((IPG_LONG_NS + CLK_NS - 1) / CLK_NS);
  // ==========================================================
  // State
  // ==========================================================
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_FRAME = 3'h2,
    ST_GAP = 3'h4
  } tpg_state_type;
  typedef struct packed {
    tpg_state_type st;
    logic [13:0] idx;
    logic [9:0] gap;
    logic [31:0] crc;
    logic [15:0] lfsr;
    logic [CFG_W-1:0] cfg;
    logic [15:0] pat;
    logic [13:0] blk;
    logic [24:0] tot;
    logic done;
    logic armed;
    logic [15:0] ctrl;
    logic [15:0] patreg;
    logic wait_req;
    logic [31:0] rdata;
    logic out_v;
    logic [7:0] out_d;
    logic out_l;
    logic sk_v;
    logic [7:0] sk_d;
    logic sk_l;
  } tpg_regs_type;
endpackage
`default_nettype wire

// ---- tb/tpg_sink_model.sv ----
// Stream receiver standing in for the link partner
`default_nettype none
module tpg_sink_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Byte stream
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  input wire logic tx_last_i,
  output logic tx_ready_o,
  // Stall request
  input wire logic hold_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] bytes_q[$];
  int lens_q[$];
  int gaps_q[$];
  int cur_len;
  int idle;
  logic in_gap;
  // ==========================================================
  // Receiver
  // ==========================================================
  assign tx_ready_o = ~hold_i;
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_len = 0;
      idle = 0;
      in_gap = 1'b0;
    end else if (tx_valid_i && tx_ready_o) begin
      bytes_q.push_back(tx_data_i);
      cur_len++;
      if (in_gap) begin
        gaps_q.push_back(idle);
      end
      in_gap = tx_last_i;
      idle = 0;
      if (tx_last_i) begin
        lens_q.push_back(cur_len);
        cur_len = 0;
      end
    end else if (in_gap && !tx_valid_i) begin
      idle++;
    end
  end
endmodule
`default_nettype wire

// ---- tb/ethernet_test_packet_generator_tb_top.sv ----
// Testbench of the test packet generator
`default_nettype none
module ethernet_test_packet_generator_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BLK = 3;
  localparam int BST = 7;
  localparam int LENS[4] = '{125, 64, 1518, 10000};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h00000000;
  logic [3:0] be = 4'hF;
  logic [31:0] rdat;
  logic wreq;
  logic [7:0] txd;
  logic txv;
  logic txl;
  logic txr;
  logic hold = 1'b0;
  logic stall = 1'b0;
  logic [31:0] rng = 32'h811377A8;
  logic [15:0] v;
  logic [15:0] c;
  logic [15:0] p;
  logic [15:0] lf = 16'h0000;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  int base;
  int n;
  always #5 clk = ~clk;
  tpg_packet_gen #(.BLOCK_PKTS(BLK), .BURST_PKTS(BST)) dut_u (
    .core_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .tx_data_o(txd), .tx_valid_o(txv),
    .tx_last_o(txl), .tx_ready_i(txr));
  tpg_sink_model sink_u (
    .core_clk_i(clk), .rst_n_i(rst_n), .tx_data_i(txd),
    .tx_valid_i(txv), .tx_last_i(txl), .tx_ready_o(txr), .hold_i(hold));
  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] crc_b(input logic [31:0] r0,
                                        input logic [7:0] b);
    logic [31:0] r;
    r = r0 ^ {24'h000000, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ tpg_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
  function automatic logic [7:0] hdr(input logic [15:0] cf, input int i);
    if (i == 5) return {4'hF, cf[9:6]};
    if (i == 11) return {4'hF, cf[5:2]};
    if (i < 12) return 8'hFF;
    if (i == 12) return tpg_pkg::ETHERTYPE[15:8];
    return tpg_pkg::ETHERTYPE[7:0];
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("Compares %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [15:0] d);
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= ~w;
    wd <= {16'h0000, d};
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    if (!w) begin
      chk(rdat[31:16], 16'h0000);
    end
    v = rdat[15:0];
    chk({15'h0000, wreq}, 16'h0000);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic idle_wait();
    int k;
    k = 0;
    do begin
      bus(1'b0, tpg_pkg::STAT_ADDR, 16'h0000);
      k++;
    end while (v[0] !== 1'b0 && k < 30000);
    // Drain the output buffer before the sink is inspected
    while (txv !== 1'b0) begin
      @(posedge clk);
    end
  endtask
  task automatic clr();
    sink_u.bytes_q.delete();
    sink_u.lens_q.delete();
    sink_u.gaps_q.delete();
    base = 0;
    lf = tpg_pkg::LFSR_SEED;
  endtask
  task automatic chk_frame(input logic [15:0] cf, input logic [15:0] pt,
                           input int f);
    int len;
    int same;
    logic [31:0] crc;
    logic [7:0] e;
    logic [7:0] g;
    len = LENS[cf[12:11]];
    same = 0;
    crc = tpg_pkg::CRC_INIT;
    chk(16'(sink_u.lens_q[f]), 16'(len));
    for (int i = 0; i < len - 4; i++) begin
      g = sink_u.bytes_q[base + i];
      e = (i < 14) ? hdr(cf, i) : (i % 2 == 0) ? pt[15:8] : pt[7:0];
      same += (i >= 14 && g === e) ? 1 : 0;
      if (cf[1] && i >= 14) begin
        e = lf[7:0];
        lf = {1'b0, lf[15:1]} ^ (lf[0] ? tpg_pkg::LFSR_TAPS : 16'h0000);
      end
      chk({8'h00, g}, {8'h00, e});
      crc = crc_b(crc, e);
    end
    crc = ~crc;
    crc[7:0] = crc[7:0] ^ {8{cf[0]}};
    for (int i = 0; i < 4; i++) begin
      g = sink_u.bytes_q[base + len - 4 + i];
      chk({8'h00, g}, {8'h00, crc[8 * i +: 8]});
    end
    if (cf[1]) begin
      chk({15'h0000, same == len - 18}, 16'h0000);
    end
    base += len;
  endtask
  // ==========================================================
  // Stall source and watchdog
  // ==========================================================
  always @(posedge clk) begin
    rng <= nxt(rng);
    hold <= stall & rng[3];
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      close_out();
    end
  end
  // ==========================================================
  // Main sequence; port kept off any live network
  // ==========================================================
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, tpg_pkg::CTRL_ADDR, 16'h0000);
    chk(v, 16'h0040);
    bus(1'b0, tpg_pkg::PAT_ADDR, 16'h0000);
    chk(v, 16'h0000);
    bus(1'b1, 8'h40, 16'hFFFF);
    bus(1'b0, 8'h40, 16'h0000);
    chk(v, 16'h0000);
    be <= 4'h1;
    bus(1'b1, tpg_pkg::PAT_ADDR, 16'hA5C3);
    be <= 4'hF;
    bus(1'b0, tpg_pkg::PAT_ADDR, 16'h0000);
    chk(v, 16'h00C3);
    clr();
    bus(1'b1, tpg_pkg::CTRL_ADDR, 16'h4800);
    repeat (40) @(posedge clk);
    chk(16'(sink_u.lens_q.size()), 16'h0000);
    stall <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      c = {3'b110, 2'(s), 1'b0, rng[9:2], 2'(s)};
      p = rng[31:16];
      clr();
      bus(1'b1, tpg_pkg::PAT_ADDR, p);
      bus(1'b1, tpg_pkg::CTRL_ADDR, c);
      bus(1'b1, tpg_pkg::CTRL_ADDR, c & 16'hBFFF);
      idle_wait();
      chk(16'(sink_u.lens_q.size()), 16'h0001);
      chk_frame(c, p, 0);
    end
    stall <= 1'b0;
    c = {3'b110, 2'b01, 1'b0, rng[9:2], 2'b00};
    p = rng[31:16];
    clr();
    bus(1'b1, tpg_pkg::PAT_ADDR, p);
    bus(1'b1, tpg_pkg::CTRL_ADDR, c);
    bus(1'b1, tpg_pkg::PAT_ADDR, ~p);
    bus(1'b1, tpg_pkg::CTRL_ADDR, c ^ 16'h1801);
    idle_wait();
    bus(1'b0, tpg_pkg::STAT_ADDR, 16'h0000);
    chk({15'h0000, v[1]}, 16'h0001);
    chk(16'(sink_u.lens_q.size()), 16'(BST));
    for (int k = 0; k < BST; k++) begin
      chk_frame(c, p, k);
    end
    for (int k = 1; k < BST; k++) begin
      n = sink_u.gaps_q[k];
      chk({15'h0000, n >= 10 && n <= 20}, 16'h0001);
    end
    c = c ^ 16'h1801;
    bus(1'b1, tpg_pkg::CTRL_ADDR, c & 16'hBFFF);
    clr();
    bus(1'b1, tpg_pkg::CTRL_ADDR, c);
    bus(1'b1, tpg_pkg::CTRL_ADDR, c & 16'hBFFF);
    idle_wait();
    chk_frame(c, ~p, 0);
    c = {3'b111, 2'b01, 1'b1, rng[9:2], 2'b10};
    clr();
    bus(1'b1, tpg_pkg::CTRL_ADDR, c);
    n = 0;
    while (sink_u.lens_q.size() < 8 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    bus(1'b1, tpg_pkg::CTRL_ADDR, c & 16'hDFFF);
    idle_wait();
    chk(16'(sink_u.lens_q.size()), 16'h0009);
    for (int k = 0; k < 9; k++) begin
      chk_frame(c, p, k);
    end
    for (int k = 1; k < 9; k++) begin
      n = sink_u.gaps_q[k];
      chk({15'h0000, n >= 820 && n <= 830}, 16'h0001);
    end
    close_out();
  end
endmodule
`default_nettype wire
